/* logic/pssq_down_timer.sv */
// Loadable down-counter used for settling and purge timing
`timescale 1ns/1ps
`default_nettype none
module pssq_down_timer #(
  parameter int unsigned WIDTH = 24
) (
  // Clock and reset
  input  wire logic             mclk_in,
  input  wire logic             arst_n_in,
  // Control
  input  wire logic             load_in,
  input  wire logic [WIDTH-1:0] value_in,
  // Status
  output logic                  busy_out,
  output logic                  done_out
);

  logic [WIDTH-1:0] cnt_reg;
  logic             busy_reg;

  // Load wins over counting so a restart never sees a stale zero
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt_reg  <= '0;
      busy_reg <= 1'b0;
    end else if (load_in) begin
      cnt_reg  <= value_in;
      busy_reg <= 1'b1;
    end else if (cnt_reg != '0) begin
      cnt_reg  <= cnt_reg - 1'b1;
    end else begin
      busy_reg <= 1'b0;
    end
  end

  assign busy_out = busy_reg;
  assign done_out = busy_reg && (cnt_reg == '0);

endmodule
`default_nettype wire

/* logic/pssq_pkg.sv */
// Package: constants and state type for the pump sample cycle sequencer
package pssq_pkg;

  // ****************************************************************
  // Sensor and arithmetic
  // ****************************************************************
  localparam int unsigned PSSQ_COUNTS_PER_REV   = 16;  // Pulses per revolution
  localparam int unsigned PSSQ_CNT_W            = 24;  // Revolution counter width
  localparam int unsigned PSSQ_VOL_W            = 16;  // Volume word width
  localparam int unsigned PSSQ_TMR_W            = 24;  // Timer width

  // ****************************************************************
  // Default timing, in microseconds and derived cycles at 40 MHz
  // ****************************************************************
  localparam int unsigned PSSQ_CLK_MHZ          = 40;
  localparam int unsigned PSSQ_SETTLE_US        = 20000;
  localparam int unsigned PSSQ_SETTLE_CYC       = PSSQ_SETTLE_US * PSSQ_CLK_MHZ;
  localparam int unsigned PSSQ_PURGE_US         = 2000000;
  localparam int unsigned PSSQ_PURGE_CYC        = PSSQ_PURGE_US * PSSQ_CLK_MHZ;
  localparam int unsigned PSSQ_STALL_US         = 400000;
  localparam int unsigned PSSQ_STALL_CYC        = PSSQ_STALL_US * PSSQ_CLK_MHZ;

  // ****************************************************************
  // Keypad and display
  // ****************************************************************
  localparam int unsigned PSSQ_KEY_POSITIONS    = 24;
  localparam int unsigned PSSQ_KEY_ROWS         = 4;
  localparam int unsigned PSSQ_KEY_COLS         = 6;
  localparam int unsigned PSSQ_LCD_LINES        = 2;
  localparam int unsigned PSSQ_LCD_CHARS        = 20;
  localparam int unsigned PSSQ_LCD_CELLS        = PSSQ_LCD_LINES * PSSQ_LCD_CHARS;

  // ****************************************************************
  // Sequencer states
  // ****************************************************************
  typedef enum logic [7:0] {
    PSSQ_IDLE    = 8'b0000_0001,
    PSSQ_SETTLE  = 8'b0000_0010,
    PSSQ_PURGE1  = 8'b0000_0100,
    PSSQ_FILL    = 8'b0000_1000,
    PSSQ_CALC    = 8'b0001_0000,
    PSSQ_DELIVER = 8'b0010_0000,
    PSSQ_PURGE2  = 8'b0100_0000,
    PSSQ_FAULT   = 8'b1000_0000
  } pssq_state_e;

endpackage

/* logic/pssq_sequencer.sv */
// Pump sample cycle sequencer: relay, motor, pulse counting, volume metering
`timescale 1ns/1ps
`default_nettype none
module pssq_sequencer
  import pssq_pkg::*;
#(
  parameter int unsigned COUNTS_PER_REV = PSSQ_COUNTS_PER_REV,
  parameter int unsigned CNT_W          = PSSQ_CNT_W,
  parameter int unsigned VOL_W          = PSSQ_VOL_W,
  parameter int unsigned TMR_W          = PSSQ_TMR_W
) (
  // Clock and reset
  input  wire logic                  mclk_in,
  input  wire logic                  arst_n_in,
  // Event control
  input  wire logic                  event_start_in,
  input  wire logic                  fault_clear_in,
  // Programming
  input  wire logic [VOL_W-1:0]      target_volume_in,
  input  wire logic [VOL_W-1:0]      line_volume_in,
  input  wire logic [TMR_W-1:0]      settle_cycles_in,
  input  wire logic [TMR_W-1:0]      purge_cycles_in,
  input  wire logic [TMR_W-1:0]      stall_cycles_in,
  // Pump board connector
  input  wire logic                  revolution_pulse_in,
  input  wire logic                  liquid_present_in,
  output logic                       direction_relay_out,
  output logic                       motor_run_out,
  output logic                       optosensor_power_out,
  // Keypad connector, row scan and column sense
  input  wire logic [PSSQ_KEY_COLS-1:0] key_cols_in,
  output logic [PSSQ_KEY_ROWS-1:0]   key_rows_out,
  output logic                       key_valid_out,
  output logic [4:0]                 key_code_out,
  // Serial port connector
  input  wire logic                  serial_attach_in,
  input  wire logic                  serial_rx_valid_in,
  input  wire logic [7:0]            serial_rx_data_in,
  output logic                       serial_attached_out,
  output logic [7:0]                 serial_rx_char_out,
  output logic                       serial_tx_valid_out,
  output logic [7:0]                 serial_tx_data_out,
  // Display position of status text
  output logic                       lcd_line_out,
  output logic [4:0]                 lcd_col_out,
  // Status
  output logic                       busy_out,
  output logic                       fault_out,
  output logic [CNT_W-1:0]           fill_revs_out,
  output logic [CNT_W-1:0]           deliver_revs_out,
  output logic [VOL_W-1:0]           vol_per_rev_out
);

  // ****************************************************************
  // State and storage
  // ****************************************************************
  pssq_state_e      state_reg;
  pssq_state_e      after_settle_reg;
  logic             dir_fwd_reg;
  logic             run_reg;
  logic             fault_reg;
  logic             pulse_d_reg;
  logic [$clog2(COUNTS_PER_REV)-1:0] sub_reg;
  logic [CNT_W-1:0] revs_reg;
  logic [CNT_W-1:0] fill_revs_reg;
  logic [CNT_W-1:0] target_revs_reg;
  logic [VOL_W-1:0] vpr_reg;
  logic             pulse_rise;
  logic             rev_tick;
  logic             tmr_load;
  logic [TMR_W-1:0] tmr_value;
  logic             tmr_busy;
  logic             tmr_done;
  logic [TMR_W-1:0] stall_reg;
  logic             stall_hit;

  // ****************************************************************
  // Phase timer
  // ****************************************************************
  pssq_down_timer #(.WIDTH(TMR_W)) pssq_down_timer_i (
    .mclk_in   (mclk_in),
    .arst_n_in (arst_n_in),
    .load_in   (tmr_load),
    .value_in  (tmr_value),
    .busy_out  (tmr_busy),
    .done_out  (tmr_done)
  );

  // Pulse edge and revolution tick from fixed counts per revolution
  assign pulse_rise = revolution_pulse_in && !pulse_d_reg;
  assign rev_tick   = pulse_rise &&
                      (sub_reg == ($clog2(COUNTS_PER_REV))'(COUNTS_PER_REV-1));

  // Timer is loaded when the settle or a purge phase begins
  always_comb begin
    tmr_load  = 1'b0;
    tmr_value = settle_cycles_in;
    case (state_reg)
      PSSQ_IDLE: begin
        tmr_load = event_start_in && !fault_reg;
      end
      PSSQ_SETTLE: begin
        tmr_load  = tmr_done;
        tmr_value = purge_cycles_in;
      end
      PSSQ_PURGE1: begin
        tmr_load = tmr_done;  // Relay must settle again before fill
      end
      PSSQ_FILL: begin
        tmr_load = liquid_present_in;
      end
      PSSQ_DELIVER: begin
        tmr_load = (revs_reg >= target_revs_reg);
      end
      default: begin
        tmr_load = 1'b0;
      end
    endcase
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  // Settling precedes every run except delivery, which follows fill via calc; purges time out on the loaded timer
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_reg        <= PSSQ_IDLE;
      after_settle_reg <= PSSQ_PURGE1;
    end else begin
      case (state_reg)
        PSSQ_IDLE: begin
          if (event_start_in && !fault_reg) begin
            state_reg        <= PSSQ_SETTLE;
            after_settle_reg <= PSSQ_PURGE1;
          end
        end
        PSSQ_SETTLE: begin
          if (tmr_done) begin
            state_reg <= after_settle_reg;
          end
        end
        PSSQ_PURGE1: begin
          if (stall_hit) begin
            state_reg <= PSSQ_FAULT;
          end else if (tmr_done) begin
            state_reg        <= PSSQ_SETTLE;
            after_settle_reg <= PSSQ_FILL;
          end
        end
        PSSQ_FILL: begin
          if (stall_hit) begin
            state_reg <= PSSQ_FAULT;
          end else if (liquid_present_in) begin
            state_reg <= PSSQ_CALC;
          end
        end
        PSSQ_CALC: begin
          state_reg <= PSSQ_DELIVER;
        end
        PSSQ_DELIVER: begin
          if (stall_hit) begin
            state_reg <= PSSQ_FAULT;
          end else if (revs_reg >= target_revs_reg) begin
            state_reg        <= PSSQ_SETTLE;
            after_settle_reg <= PSSQ_PURGE2;
          end
        end
        PSSQ_PURGE2: begin
          if (stall_hit) begin
            state_reg <= PSSQ_FAULT;
          end else if (tmr_done) begin
            state_reg <= PSSQ_IDLE;
          end
        end
        PSSQ_FAULT: begin
          state_reg <= PSSQ_IDLE;
        end
        default: begin
          state_reg <= PSSQ_IDLE;
        end
      endcase
    end
  end

  // Direction: reverse except while heading into or running fill/delivery
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      dir_fwd_reg <= 1'b0;
    end else begin
      case (state_reg)
        PSSQ_SETTLE: begin
          dir_fwd_reg <= (after_settle_reg == PSSQ_FILL);
        end
        PSSQ_FILL, PSSQ_CALC, PSSQ_DELIVER: begin
          dir_fwd_reg <= 1'b1;
        end
        default: begin
          dir_fwd_reg <= 1'b0;
        end
      endcase
    end
  end

  // Run is high only in pumping phases, never during relay settling
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      run_reg <= 1'b0;
    end else begin
      case (state_reg)
        PSSQ_SETTLE: run_reg <= tmr_done && !tmr_load;
        PSSQ_PURGE1: run_reg <= !stall_hit && !tmr_done;
        PSSQ_FILL: run_reg <= !stall_hit && !liquid_present_in;
        PSSQ_CALC: run_reg <= 1'b1;
        PSSQ_DELIVER: run_reg <= !stall_hit && (revs_reg < target_revs_reg);
        PSSQ_PURGE2: run_reg <= !stall_hit && !tmr_done;
        default: run_reg <= 1'b0;
      endcase
    end
  end

  // ****************************************************************
  // Counting and delivery arithmetic
  // ****************************************************************
  // Pulses count only while the motor runs; revolution count reset per phase
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pulse_d_reg <= 1'b0;
      sub_reg     <= '0;
      revs_reg    <= '0;
    end else begin
      pulse_d_reg <= revolution_pulse_in;
      if (state_reg == PSSQ_SETTLE || state_reg == PSSQ_CALC) begin
        sub_reg  <= '0;
        revs_reg <= '0;
      end else if (run_reg && pulse_rise) begin
        sub_reg <= rev_tick ? '0 : sub_reg + 1'b1;
        if (rev_tick) begin
          revs_reg <= revs_reg + 1'b1;
        end
      end
    end
  end

  // Fill revolutions captured at detection; volume per revolution follows
  // from the known line volume, so suction head is folded in each event.
  // Divide is sequential-free for clarity; it sits in one long path.
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      fill_revs_reg   <= '0;
      vpr_reg         <= '0;
      target_revs_reg <= '0;
    end else if (state_reg == PSSQ_FILL && liquid_present_in) begin
      fill_revs_reg <= revs_reg;
      vpr_reg <= (revs_reg == '0) ? line_volume_in :
                 VOL_W'(CNT_W'(line_volume_in) / revs_reg);
    end else if (state_reg == PSSQ_CALC) begin
      target_revs_reg <= (vpr_reg == '0) ? CNT_W'(target_volume_in) :
                         CNT_W'((CNT_W'(target_volume_in) + CNT_W'(vpr_reg)
                                 - 1'b1) / CNT_W'(vpr_reg));
    end
  end

  // Stall watchdog: any pulse or non-running motor reloads it
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      stall_reg <= '0;
    end else if (!run_reg || pulse_rise) begin
      stall_reg <= stall_cycles_in;
    end else if (stall_reg != '0) begin
      stall_reg <= stall_reg - 1'b1;
    end
  end
  assign stall_hit = run_reg && (stall_reg == '0) &&
                     (stall_cycles_in != '0);

  // Fault is sticky until cleared; a new stall wins over the clear
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      fault_reg <= 1'b0;
    end else if (stall_hit) begin
      fault_reg <= 1'b1;
    end else if (fault_clear_in) begin
      fault_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // Keypad scan, 4 rows by 6 columns
  // ****************************************************************
  logic [1:0] row_reg;
  logic       key_v_reg;
  logic [4:0] key_c_reg;
  logic [2:0] col_idx;
  logic       col_hit;

  // Lowest pressed column wins when several keys share a row
  always_comb begin
    col_idx = '0;
    col_hit = 1'b0;
    for (int i = PSSQ_KEY_COLS - 1; i >= 0; i--) begin
      if (key_cols_in[i]) begin
        col_idx = 3'(i);
        col_hit = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      row_reg   <= '0;
      key_v_reg <= 1'b0;
      key_c_reg <= '0;
    end else begin
      row_reg   <= (row_reg == 2'(PSSQ_KEY_ROWS - 1)) ? '0 : row_reg + 1'b1;
      key_v_reg <= col_hit;
      key_c_reg <= 5'(row_reg * PSSQ_KEY_COLS + col_idx);
    end
  end
  assign key_rows_out  = PSSQ_KEY_ROWS'(1) << row_reg;
  assign key_valid_out = key_v_reg;
  assign key_code_out  = key_c_reg;

  // ****************************************************************
  // Serial port and display position
  // ****************************************************************
  logic       att_reg;
  logic [7:0] rx_reg;
  logic       tx_v_reg;
  logic [7:0] tx_d_reg;
  logic       line_reg;
  logic [4:0] col_reg;
  logic       st_change;
  pssq_state_e st_d_reg;

  assign st_change = (state_reg != st_d_reg);

  // Status byte sent on each phase change, only when a device is attached
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      att_reg  <= 1'b0;
      rx_reg   <= '0;
      tx_v_reg <= 1'b0;
      tx_d_reg <= '0;
      st_d_reg <= PSSQ_IDLE;
    end else begin
      att_reg  <= serial_attach_in;
      st_d_reg <= state_reg;
      if (serial_rx_valid_in) begin
        rx_reg <= serial_rx_data_in;
      end
      tx_v_reg <= st_change && att_reg;
      tx_d_reg <= {fault_reg, state_reg[6:0]};
    end
  end

  // Status text cursor walks 2 lines of 20 characters
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      line_reg <= 1'b0;
      col_reg  <= '0;
    end else if (st_change) begin
      if (col_reg == 5'(PSSQ_LCD_CHARS - 1)) begin
        col_reg  <= '0;
        line_reg <= ~line_reg;
      end else begin
        col_reg <= col_reg + 1'b1;
      end
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign direction_relay_out  = dir_fwd_reg;
  assign motor_run_out        = run_reg;
  assign optosensor_power_out = run_reg;
  assign serial_attached_out  = att_reg;
  assign serial_rx_char_out   = rx_reg;
  assign serial_tx_valid_out  = tx_v_reg;
  assign serial_tx_data_out   = tx_d_reg;
  assign lcd_line_out         = line_reg;
  assign lcd_col_out          = col_reg;
  assign busy_out             = (state_reg != PSSQ_IDLE);
  assign fault_out            = fault_reg;
  assign fill_revs_out        = fill_revs_reg;
  assign deliver_revs_out     = target_revs_reg;
  assign vol_per_rev_out      = vpr_reg;

endmodule
`default_nettype wire

/* test/pssq_pump_board_model.sv */
// Model of the pump motor board: optical counter and liquid sensing
`timescale 1ns/1ps
`default_nettype none
module pssq_pump_board_model (
  // Clock and reset
  input  wire logic        mclk_in,
  input  wire logic        arst_n_in,
  // Scenario control
  input  wire logic [15:0] fill_pulses_in,
  input  wire logic        stall_in,
  // Pump board connector
  input  wire logic        direction_relay_in,
  input  wire logic        motor_run_in,
  output logic             revolution_pulse_out,
  output logic             liquid_present_out
);
  logic [2:0]  phase_reg;
  logic [15:0] fwd_reg;
  // Rotor disk phase; returns to zero while the motor is off
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      phase_reg <= 3'h0;
    end else begin
      phase_reg <= motor_run_in ? phase_reg + 3'h1 : 3'h0;
    end
  end
  // Emitter unpowered when stopped, so no pulse then
  assign revolution_pulse_out = motor_run_in && !stall_in && phase_reg[2];
  // Reverse air empties the line; liquid lags the last fill pulse
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      fwd_reg            <= 16'h0000;
      liquid_present_out <= 1'b0;
    end else if (motor_run_in && !direction_relay_in) begin
      fwd_reg            <= 16'h0000;
      liquid_present_out <= 1'b0;
    end else if (motor_run_in && !stall_in && phase_reg == 3'h3) begin
      fwd_reg <= fwd_reg + 16'h0001;
    end else if (phase_reg == 3'h6 && fwd_reg >= fill_pulses_in) begin
      liquid_present_out <= 1'b1;
    end
  end
endmodule
`default_nettype wire

/* test/pssq_sequencer_monitor.sv */
// Checker: port-level properties of the pump sample cycle sequencer
`timescale 1ns/1ps
`default_nettype none
module pssq_sequencer_monitor (
  // Clock and reset
  input wire logic        mclk_in,
  input wire logic        arst_n_in,
  // Stimulus seen by the design
  input wire logic        event_start_in,
  input wire logic [23:0] stall_cycles_in,
  input wire logic        revolution_pulse_in,
  // Pump board and status outputs
  input wire logic        direction_relay_out,
  input wire logic        motor_run_out,
  input wire logic        optosensor_power_out,
  input wire logic        busy_out,
  input wire logic        fault_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);
  // ****************************************************************
  // Helper: cycles spent running since the last pulse edge
  // ****************************************************************
  logic [24:0] dry_reg;
  logic        pulse_reg;
  // A dead sensor must trip the fault long before this overflows
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      dry_reg   <= 25'h000_0000;
      pulse_reg <= 1'b0;
    end else begin
      pulse_reg <= revolution_pulse_in;
      if (motor_run_out && !(revolution_pulse_in && !pulse_reg)) begin
        dry_reg <= dry_reg + 25'h000_0001;
      end else begin
        dry_reg <= 25'h000_0000;
      end
    end
  end
  // ****************************************************************
  // Properties
  // ****************************************************************
  property p_idle_reverse;
    !busy_out |-> !direction_relay_out;
  endproperty
  a_idle_reverse: assert property (p_idle_reverse)
    else $error("relay not reverse while idle");
  property p_settle_first;
    $rose(motor_run_out) |-> $stable(direction_relay_out) &&
      $past(direction_relay_out, 3) == direction_relay_out;
  endproperty
  a_settle_first: assert property (p_settle_first)
    else $error("motor started before relay settled");
  property p_no_hot_switch;
    $changed(direction_relay_out) |-> !motor_run_out [*3];
  endproperty
  a_no_hot_switch: assert property (p_no_hot_switch)
    else $error("relay switched under load");
  property p_emitter;
    optosensor_power_out == motor_run_out;
  endproperty
  a_emitter: assert property (p_emitter)
    else $error("sensor power differs from motor run");
  property p_fault_stops;
    fault_out |-> !motor_run_out;
  endproperty
  a_fault_stops: assert property (p_fault_stops)
    else $error("motor running while faulted");
  property p_start_taken;
    event_start_in && !busy_out && !fault_out |=> busy_out;
  endproperty
  a_start_taken: assert property (p_start_taken)
    else $error("event start not taken");
  property p_end_off;
    $fell(busy_out) |-> !motor_run_out && !direction_relay_out;
  endproperty
  a_end_off: assert property (p_end_off)
    else $error("event ended with motor powered");
  property p_stall_bound;
    stall_cycles_in != 24'h00_0000 |->
      dry_reg <= {1'b0, stall_cycles_in} + 25'h000_0004;
  endproperty
  a_stall_bound: assert property (p_stall_bound)
    else $error("pump kept running without pulses");
  // Main scenarios reached
  c_fwd_run: cover property ($rose(motor_run_out) && direction_relay_out);
  c_fault: cover property ($rose(fault_out));
  c_done: cover property ($fell(busy_out));
endmodule
bind pssq_sequencer pssq_sequencer_monitor pssq_sequencer_monitor_i (
  .mclk_in, .arst_n_in, .event_start_in, .stall_cycles_in,
  .revolution_pulse_in, .direction_relay_out, .motor_run_out,
  .optosensor_power_out, .busy_out, .fault_out);
`default_nettype wire

/* test/pump_sample_cycle_sequencer_tb.sv */
// Testbench: sample events, delivery arithmetic and stall fault
`timescale 1ns/1ps
`default_nettype none
module pump_sample_cycle_sequencer_tb;
  import pssq_pkg::*;
  logic        mclk_in, arst_n_in, event_start, fault_clear, stall_m;
  logic [15:0] target_volume, line_volume, fill_pulses;
  logic [23:0] settle, purge, stall;
  logic        pulse, liquid, relay, run, opto, busy, fault, pulse_d;
  logic [3:0]  key_rows;
  logic [5:0]  key_cols;
  logic [4:0]  key_code, lcd_col;
  logic [7:0]  rx_data, rx_char, tx_data;
  logic        key_valid, attach, rx_valid, attached, tx_valid, lcd_line;
  logic [23:0] fill_revs, deliver_revs;
  logic [15:0] vpr;
  logic [31:0] fwd_seen;
  int          miscompares, total_checks;
  pssq_sequencer pssq_sequencer_i (
    .mclk_in, .arst_n_in, .event_start_in(event_start),
    .fault_clear_in(fault_clear), .target_volume_in(target_volume),
    .line_volume_in(line_volume), .settle_cycles_in(settle),
    .purge_cycles_in(purge), .stall_cycles_in(stall),
    .revolution_pulse_in(pulse), .liquid_present_in(liquid),
    .direction_relay_out(relay), .motor_run_out(run),
    .optosensor_power_out(opto), .key_cols_in(key_cols),
    .key_rows_out(key_rows), .key_valid_out(key_valid),
    .key_code_out(key_code), .serial_attach_in(attach),
    .serial_rx_valid_in(rx_valid), .serial_rx_data_in(rx_data),
    .serial_attached_out(attached), .serial_rx_char_out(rx_char),
    .serial_tx_valid_out(tx_valid), .serial_tx_data_out(tx_data),
    .lcd_line_out(lcd_line), .lcd_col_out(lcd_col),
    .busy_out(busy), .fault_out(fault), .fill_revs_out(fill_revs),
    .deliver_revs_out(deliver_revs), .vol_per_rev_out(vpr));
  pssq_pump_board_model pssq_pump_board_model_i (
    .mclk_in, .arst_n_in, .fill_pulses_in(fill_pulses),
    .stall_in(stall_m), .direction_relay_in(relay),
    .motor_run_in(run), .revolution_pulse_out(pulse),
    .liquid_present_out(liquid));
  // ****************************************************************
  // Clock, pulse tally and watchdog
  // ****************************************************************
  initial begin
    mclk_in = 1'b0;
    forever #12.5 mclk_in = ~mclk_in;
  end
  // Forward pulses seen on the wire, cleared per event
  always @(posedge mclk_in) begin
    pulse_d <= pulse;
    if (pulse && !pulse_d && relay) fwd_seen <= fwd_seen + 32'h0000_0001;
  end
  // Four events need about 3000 cycles; allow far more
  initial begin
    repeat (20000) @(posedge mclk_in);
    miscompares++;
    summarize();
  end
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge mclk_in);
    #2;
  endtask
  // Select 0 run, 1 busy, 2 fault; returns edges waited
  task automatic wait_until(input int sel, input logic lvl, output int n);
    n = 0;
    while ((sel == 0 ? run : sel == 1 ? busy : fault) !== lvl &&
           n < 3000) begin
      tick(1);
      n++;
    end
    check({31'h0, n < 3000}, 32'h0000_0001);
  endtask
  task automatic pulse_start();
    event_start = 1'b1;
    tick(1);
    event_start = 1'b0;
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic sample_event(input logic [15:0] pulses,
      input logic [15:0] tgt, input logic [23:0] revs,
      input logic [15:0] v, input logic [23:0] del);
    int n;
    fill_pulses   = pulses;
    target_volume = tgt;
    fwd_seen      = 32'h0000_0000;
    pulse_start();
    wait_until(0, 1'b1, n);
    check(n, settle + 24'h00_0002);
    check(relay, 1'b0);
    wait_until(0, 1'b0, n);
    wait_until(0, 1'b1, n);
    check(relay, 1'b1);
    pulse_start();
    // Run dips for one cycle at detection, then delivery runs forward
    wait_until(0, 1'b0, n);
    wait_until(0, 1'b1, n);
    check(relay, 1'b1);
    wait_until(0, 1'b0, n);
    wait_until(0, 1'b1, n);
    check(n, settle + 24'h00_0002);
    check(relay, 1'b0);
    wait_until(1, 1'b0, n);
    check(fill_revs, revs);
    check(vpr, v);
    check(deliver_revs, del);
    check(fwd_seen, pulses + del * PSSQ_COUNTS_PER_REV);
    tick(3);
    check(busy, 1'b0);
  endtask
  task automatic stall_event();
    int n;
    stall_m = 1'b1;
    pulse_start();
    tick(1);
    check({tx_valid, tx_data}, 9'h102);
    wait_until(2, 1'b1, n);
    check(run, 1'b0);
    // Start lands while idle but faulted, so it must be refused
    tick(1);
    pulse_start();
    fault_clear = 1'b1;
    tick(1);
    fault_clear = 1'b0;
    stall_m     = 1'b0;
    tick(3);
    check(fault, 1'b0);
    check(busy, 1'b0);
  endtask
  task automatic aux_ports();
    key_cols = 6'h04;
    while (key_rows !== 4'h4) tick(1);
    tick(1);
    check({key_valid, key_code}, 6'h2E);
    key_cols = 6'h00;
    attach   = 1'b0;
    rx_valid = 1'b1;
    rx_data  = 8'hA5;
    tick(1);
    check({attached, rx_char}, 9'h0A5);
    attach   = 1'b1;
    rx_valid = 1'b0;
    tick(1);
    check(attached, 1'b1);
  endtask
  task automatic summarize();
    $display("checks=%0d miscompares=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    arst_n_in = 1'b0;
    {event_start, fault_clear, stall_m} = 3'h0;
    {attach, rx_valid, rx_data, key_cols} = 16'h8000;
    {target_volume, fill_pulses} = 32'h0000_0000;
    line_volume = 16'h0064;
    settle = 24'h00_0004;
    purge  = 24'h00_0014;
    stall  = 24'h00_00C8;
    fwd_seen = 32'h0000_0000;
    miscompares = 0;
    total_checks = 0;
    tick(8);
    check({relay, run, opto, busy}, 4'h0);
    check(key_rows, 4'h1);
    tick(8);
    arst_n_in = 1'b1;
    tick(1);
    aux_ports();
    sample_event(16'h0050, 16'h0046, 24'h00_0005, 16'h0014, 24'h00_0004);
    sample_event(16'h0020, 16'h0046, 24'h00_0002, 16'h0032, 24'h00_0002);
    sample_event(16'h0030, 16'h0064, 24'h00_0003, 16'h0021, 24'h00_0004);
    // Nine phase changes per event: 27 wraps once past 20 columns
    check({lcd_line, lcd_col}, 6'h27);
    stall_event();
    summarize();
  end
endmodule
`default_nettype wire
